// >>> bench/jtag_host_model.sv
// Purpose: Programmer model that steps the test port
// Assumes: Starts each scan from Run-Test/Idle
// Notes:   TCK period of 125 ns, free of sys_clk, TCK idles low
`timescale 1ns/1ps
module jtag_host_model (
    // Clock
    input wire logic                 sys_clk,
    // Link pins
    output jtag_prog_pkg::port_pins_t pins,
    input wire logic                 tdo
);
    import jtag_prog_pkg::*;
    initial pins = '0;
    task automatic tick(input logic tms, input logic tdi, output logic seen);
        pins.tms <= tms;
        pins.tdi <= tdi;
        #62.5;
        seen = tdo;
        pins.tck <= 1'b1;
        #62.5;
        pins.tck <= 1'b0;
    endtask
    // Five ones reach Test-Logic-Reset, a zero reaches idle
    task automatic idle();
        logic s;
        for (int i = 0; i < 6; i++) tick(i < 5, 1'b0, s);
    endtask
    // One IR or DR scan ending in Run-Test/Idle
    task automatic scan(input logic ir, input logic [15:0] val, input int n,
                        output logic [15:0] got);
        logic s;
        got = '0;
        tick(1'b1, 1'b0, s);
        if (ir) tick(1'b1, 1'b0, s);
        tick(1'b0, 1'b0, s);
        tick(1'b0, 1'b0, s);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, val[i], s);
            got[i] = s;
        end
        tick(1'b1, 1'b0, s);
        tick(1'b0, 1'b0, s);
        // Hand back on a clock edge so the bench drives in step
        @(posedge sys_clk);
    endtask
endmodule

// >>> bench/jtag_port_chk.sv
// Purpose: Port-level timing checks for the programming port
// Assumes: TIMEOUT_SEL0 of at least 4 cycles
// Notes:   Sees only the top-level ports
`timescale 1ns/1ps
module jtag_port_chk #(
    parameter int unsigned TIMEOUT_SEL0 = 16   // Shortest reset time-out
) (
    // Watched ports
    input wire logic                       sys_clk,
    input wire logic                       reset,
    input wire logic                       testPortEnableFuse,
    input wire logic                       extResetN,
    input wire logic                       ctrlWrite,
    input wire logic                       testPortDisableBit,
    input wire logic                       tdoOe,
    input wire logic                       coreReset,
    input wire logic [15:0]                addrIn,
    input wire logic                       addrLoad,
    input wire logic                       flashCmdStrobe,
    input wire jtag_prog_pkg::page_write_t pageWrite,
    input wire logic [15:0]                wordAddr,
    input wire logic                       progMode
);
    import jtag_prog_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic [15:0] lowAddr_reg;  // Word of the latest low-byte write
    // A high byte must land on the word its low byte used
    always_ff @(posedge sys_clk) begin
        if (pageWrite.strobe && !pageWrite.high) begin
            lowAddr_reg <= pageWrite.addr;
        end
    end
    property p_fuse; !testPortEnableFuse [*3] |-> !tdoOe; endproperty
    a_fuse: assert property (p_fuse) else $error("tdo driven, fuse off");
    property p_dis; testPortDisableBit [*2] |-> !tdoOe; endproperty
    a_dis: assert property (p_dis) else $error("tdo driven, port off");
    property p_clr; testPortDisableBit && !extResetN && !ctrlWrite |-> ##[1:6] !testPortDisableBit;
    endproperty
    a_clr: assert property (p_clr) else $error("disable bit kept");
    property p_ext; !extResetN |-> ##[1:4] coreReset; endproperty
    a_ext: assert property (p_ext) else $error("core not reset");
    property p_hold; $rose(extResetN) && coreReset |-> coreReset [*4]; endproperty
    a_hold: assert property (p_hold) else $error("reset time-out short");
    property p_mode; flashCmdStrobe || pageWrite.strobe |-> progMode; endproperty
    a_mode: assert property (p_mode) else $error("action while locked");
    property p_exe; flashCmdStrobe |=> !flashCmdStrobe; endproperty
    a_exe: assert property (p_exe) else $error("execute pulse too long");
    property p_pw; pageWrite.strobe |=> !pageWrite.strobe; endproperty
    a_pw: assert property (p_pw) else $error("page write pulse too long");
    property p_pair; pageWrite.strobe && pageWrite.high |-> pageWrite.addr == lowAddr_reg;
    endproperty
    a_pair: assert property (p_pair) else $error("high byte on other word");
    property p_load; addrLoad |=> wordAddr == $past(addrIn); endproperty
    a_load: assert property (p_load) else $error("address load lost");
endmodule
bind jtag_programming_port jtag_port_chk #(.TIMEOUT_SEL0(TIMEOUT_SEL0)) chk (.sys_clk, .reset,
    .testPortEnableFuse, .extResetN, .ctrlWrite, .testPortDisableBit, .tdoOe, .coreReset,
    .addrIn, .addrLoad, .flashCmdStrobe, .pageWrite, .wordAddr, .progMode);

// >>> bench/jtag_programming_port_test.sv
// Purpose: Self-checking bench for the programming port
// Assumes: Reset time-outs shortened to 4..16 cycles
// Notes:   Flash side is plain input values, random except flashBusy and addrLoad
`timescale 1ns/1ps
module jtag_programming_port_test;
    import jtag_prog_pkg::*;
    logic sys_clk = 0, reset = 1, fuse = 1, extResetN = 1, ctrlWrite = 0, ctrlData = 0;
    logic flashBusy = 0, addrLoad = 0, tdo, tdoOe, disBit, coreReset, cmdStb, progMode;
    logic [1:0] clkOpt = 2'h0;
    logic [14:0] cmdResult = 15'h0000, flashCmd;
    logic [15:0] addrIn = 16'h0000, readWord = 16'h0000, wordAddr;
    port_pins_t pins;
    page_write_t pageWrite, pwQ[$];  // Expected page-buffer writes
    logic [15:0] cmdQ[$];            // Expected applied commands
    int miscompares = 0, tests_run = 0;
    always #4 sys_clk = ~sys_clk;
    jtag_programming_port #(.TIMEOUT_SEL0(4), .TIMEOUT_SEL1(8), .TIMEOUT_SEL2(12),
        .TIMEOUT_SEL3(16)) DUT (.sys_clk, .reset, .portPins(pins), .tdo, .tdoOe,
        .testPortEnableFuse(fuse), .clockOptionFuse(clkOpt), .extResetN, .ctrlWrite,
        .ctrlDisableData(ctrlData), .testPortDisableBit(disBit), .coreReset, .cmdResult,
        .flashBusy, .addrIn, .addrLoad, .flashReadWord(readWord), .flashCmd,
        .flashCmdStrobe(cmdStb), .pageWrite, .wordAddr, .progMode);
    jtag_host_model host (.sys_clk, .pins, .tdo);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkPw(input page_write_t got, input page_write_t exp);
        chk(got.addr, exp.addr);
        chk({6'h00, got.strobe, got.high, got.data}, {6'h00, exp.strobe, exp.high, exp.data});
    endtask
    task automatic final_report();
        if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Each result takes the oldest note
    always @(posedge sys_clk) begin
        if (cmdStb === 1'b1) chk({1'b0, flashCmd}, cmdQ.size() ? cmdQ.pop_front() : '1);
        if (pageWrite.strobe === 1'b1) chkPw(pageWrite, pwQ.size() ? pwQ.pop_front() : '0);
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        final_report();
    end
    initial begin
        logic [15:0] got, a, w;
        void'($urandom(63336));
        clkOpt <= 2'($urandom_range(3));
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (3) @(posedge sys_clk);
        fuse <= 1'b0;
        host.scan(1'b1, 16'h000C, 4, got);
        chk(got, 16'h0000);
        fuse <= 1'b1;
        ctrlWrite <= 1'b1;
        ctrlData <= 1'b1;
        @(posedge sys_clk);
        ctrlWrite <= 1'b0;
        extResetN <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk({disBit, coreReset}, 16'h0001);
        extResetN <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk(coreReset, 16'h0001);
        repeat (36) @(posedge sys_clk);
        host.idle();
        host.scan(1'b1, 16'h000C, 4, got);
        chk(got, 16'h0001);
        host.scan(1'b0, 16'h0001, 1, got);
        chk(coreReset, 16'h0001);
        host.scan(1'b0, 16'h0000, 1, got);
        repeat (40) @(posedge sys_clk);
        chk(coreReset, 16'h0000);
        host.scan(1'b1, 16'h0004, 4, got);
        host.scan(1'b0, UNLOCK_KEY ^ 16'h0100, 16, got);
        chk(got, 16'h0000);
        chk(progMode, 16'h0000);
        host.scan(1'b0, UNLOCK_KEY, 16, got);
        chk(progMode, 16'h0001);
        host.scan(1'b1, 16'h0005, 4, got);
        for (int k = 0; k < 2; k++) begin
            cmdResult <= 15'($urandom);
            flashBusy <= ~k[0];
            w = 16'($urandom_range(32767));
            cmdQ.push_back(w);
            host.scan(1'b0, w, 15, got);
            chk(got, {1'b0, cmdResult[14:10], ~k[0], cmdResult[8:0]});
        end
        a = 16'($urandom);
        addrIn <= a;
        addrLoad <= 1'b1;
        @(posedge sys_clk);
        addrLoad <= 1'b0;
        host.scan(1'b1, 16'h0006, 4, got);
        for (int k = 0; k < 4; k++) begin
            w = 16'($urandom_range(255));
            pwQ.push_back({1'b1, k[0], a + 16'(k / 2), w[7:0]});
            host.scan(1'b0, w, 8, got);
        end
        chk(16'(pwQ.size()), 16'h0000);
        readWord <= 16'($urandom);
        addrLoad <= 1'b1;
        @(posedge sys_clk);
        addrLoad <= 1'b0;
        host.scan(1'b1, 16'h0007, 4, got);
        host.scan(1'b0, 16'h0000, 8, got);
        chk(got, {8'h00, readWord[7:0]});
        host.scan(1'b0, 16'h0000, 8, got);
        chk(got, {8'h00, readWord[15:8]});
        chk(wordAddr, a + 16'h0001);
        host.scan(1'b1, 16'h0004, 4, got);
        host.scan(1'b0, 16'h0000, 16, got);
        chk(got, UNLOCK_KEY);
        chk(progMode, 16'h0000);
        final_report();
    end
endmodule

// >>> inc/jtag_prog_pkg.sv
// Purpose: Shared types and constants for the test-port programming block
// Assumes: Test-port pins are sampled by the 125 MHz system clock
// Notes:   All shift registers move their least significant bit first
package jtag_prog_pkg;

    // Instruction register layout
    localparam int          IR_W              = 4;
    localparam logic [3:0]  IR_CAPTURE        = 4'h1;  // Pattern loaded in Capture-IR
    localparam logic [3:0]  INSTR_BYPASS      = 4'hF;  // Default after test-logic reset
    localparam logic [3:0]  HOLD_IN_RESET_INSTR = 4'hC;
    localparam logic [3:0]  UNLOCK_INSTR      = 4'h4;
    localparam logic [3:0]  COMMAND_ENTRY_INSTR = 4'h5;
    localparam logic [3:0]  PAGE_FILL_INSTR   = 4'h6;
    localparam logic [3:0]  PAGE_DUMP_INSTR   = 4'h7;

    // Data register, address and time-out widths
    localparam int          KEY_W             = 16;
    localparam int          CMD_W             = 15;
    localparam int          BYTE_W            = 8;
    localparam int          ADDR_W            = 16;
    localparam int          TIMEOUT_W         = 17;

    // Unlock signature and reset values
    localparam logic [15:0] UNLOCK_KEY        = 16'hA370;
    localparam logic [15:0] KEY_RESET         = 16'h0000;
    localparam logic [15:0] ADDR_RESET        = 16'h0000;

    // Position of the busy flag inside a captured command result
    localparam int          BUSY_BIT          = 9;

    // Chip clocks that the disable bit survives under external reset
    localparam logic [1:0]  DISABLE_CLEAR_CLKS = 2'h2;

    // Tap controller states
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE,
        TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
        TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } tap_state_t;

    // Test-port pin inputs travelling together
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } port_pins_t;

    // One byte write into the flash page buffer
    typedef struct packed {
        logic              strobe;  // One-cycle write pulse
        logic              high;    // 1 selects the high byte of the word
        logic [ADDR_W-1:0] addr;    // Word address
        logic [BYTE_W-1:0] data;    // Byte to write
    } page_write_t;

endpackage

// >>> logic/jtag_programming_port.sv
// Purpose: Programming access over the four-wire test port
// Assumes: TCK, TMS, TDI and the external reset pin are asynchronous to sys_clk
// Notes:   TCK must run well below sys_clk/4 so that every edge is seen
`timescale 1ns/1ps

module jtag_programming_port #(
    parameter int unsigned TIMEOUT_SEL0 = 16,     // Reset time-out choices in sys_clk
    parameter int unsigned TIMEOUT_SEL1 = 1024,
    parameter int unsigned TIMEOUT_SEL2 = 16384,
    parameter int unsigned TIMEOUT_SEL3 = 65536
) (
    // Clock and reset
    input  wire logic                               sys_clk,
    input  wire logic                               reset,
    // Test-port pins
    input  wire jtag_prog_pkg::port_pins_t          portPins,
    output logic                                    tdo,
    output logic                                    tdoOe,
    // Fuses and external reset pin
    input  wire logic                               testPortEnableFuse,
    input  wire logic [1:0]                         clockOptionFuse,
    input  wire logic                               extResetN,
    // Core control register access to the disable bit
    input  wire logic                               ctrlWrite,
    input  wire logic                               ctrlDisableData,
    output logic                                    testPortDisableBit,
    // Core reset
    output logic                                    coreReset,
    // Flash control side
    input  wire logic [jtag_prog_pkg::CMD_W-1:0]    cmdResult,
    input  wire logic                               flashBusy,
    input  wire logic [jtag_prog_pkg::ADDR_W-1:0]   addrIn,
    input  wire logic                               addrLoad,
    input  wire logic [15:0]                        flashReadWord,
    output logic [jtag_prog_pkg::CMD_W-1:0]         flashCmd,
    output logic                                    flashCmdStrobe,
    output jtag_prog_pkg::page_write_t              pageWrite,
    output logic [jtag_prog_pkg::ADDR_W-1:0]        wordAddr,
    output logic                                    progMode
);
    import jtag_prog_pkg::*;

    // All state of this module
    typedef struct packed {
        logic [1:0]           tckSync;      // Bit 0 is the first stage
        logic [1:0]           tmsSync;
        logic [1:0]           tdiSync;
        logic [1:0]           rstnSync;
        logic                 tckPrev;      // Last synchronised TCK level
        logic [IR_W-1:0]      irShift;      // Instruction shift stage
        logic [IR_W-1:0]      irActive;     // Current instruction
        logic                 bypassBit;
        logic                 resetChain;
        logic [KEY_W-1:0]     keyShift;
        logic                 progMode;
        logic [CMD_W-1:0]     cmdShift;     // Command chain, low byte doubles as data byte
        logic [CMD_W-1:0]     cmdApplied;
        logic                 cmdPending;   // Update seen, execute not yet given
        logic                 cmdStrobe;
        logic                 loadHigh;     // Next page-fill byte is the high one
        logic                 firstLoad;    // No byte written since page-fill entry
        logic                 readHigh;     // Next page-dump byte is the high one
        logic [ADDR_W-1:0]    wordAddr;
        page_write_t          pageWrite;
        logic [1:0]           disCount;     // Chip clocks under external reset
        logic                 disableBit;
        logic [TIMEOUT_W-1:0] timeout;
        logic                 coreReset;
        logic                 tdo;
        logic                 tdoOe;
    } port_regs_t;

    port_regs_t regs_reg;   // Registered state
    port_regs_t regs_next;  // Next state
    tap_state_t tapState;   // Current access-port state

    logic       tckRise;    // One cycle after a synchronised rising TCK
    logic       tckFall;    // One cycle after a synchronised falling TCK
    logic       portUsable; // Fuse programmed and disable bit clear

    // Time-out chosen by the clock-option fuse
    function automatic logic [TIMEOUT_W-1:0] pickTimeout(input logic [1:0] sel);
        case (sel)
            2'h0:    pickTimeout = TIMEOUT_W'(TIMEOUT_SEL0);
            2'h1:    pickTimeout = TIMEOUT_W'(TIMEOUT_SEL1);
            2'h2:    pickTimeout = TIMEOUT_W'(TIMEOUT_SEL2);
            default: pickTimeout = TIMEOUT_W'(TIMEOUT_SEL3);
        endcase
    endfunction

    // Instruction match, used by the data-register capture and update actions
    function automatic logic isInstr(input logic [IR_W-1:0] ir, input logic [IR_W-1:0] code);
        isInstr = (ir == code);
    endfunction

    // Edge detection on the second synchroniser stage only
    assign tckRise = regs_reg.tckSync[1] & ~regs_reg.tckPrev;
    assign tckFall = ~regs_reg.tckSync[1] & regs_reg.tckPrev;
    assign portUsable = testPortEnableFuse & ~regs_reg.disableBit;

    // Access-port sequencer, parked while the port is unusable
    tap_controller u_tap (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .holdReset(~portUsable),
        .tckRise  (tckRise),
        .tmsLevel (regs_reg.tmsSync[1]),
        .tapState (tapState)
    );

    // Next-state logic for the whole port
    always_comb begin
        logic [ADDR_W-1:0] nextAddr;
        nextAddr  = regs_reg.wordAddr;
        regs_next = regs_reg;

        // Two-stage synchronisers for every pin input
        regs_next.tckSync  = {regs_reg.tckSync[0], portPins.tck};
        regs_next.tmsSync  = {regs_reg.tmsSync[0], portPins.tms};
        regs_next.tdiSync  = {regs_reg.tdiSync[0], portPins.tdi};
        regs_next.rstnSync = {regs_reg.rstnSync[0], extResetN};
        regs_next.tckPrev  = regs_reg.tckSync[1];

        // Pulses last one cycle
        regs_next.cmdStrobe        = 1'b0;
        regs_next.pageWrite.strobe = 1'b0;

        // Software access to the disable bit
        if (ctrlWrite) begin
            regs_next.disableBit = ctrlDisableData;
            regs_next.disCount   = 2'h0;
        end else if (regs_reg.disableBit && !regs_reg.rstnSync[1]) begin
            if (regs_reg.disCount == DISABLE_CLEAR_CLKS - 2'h1) begin
                regs_next.disableBit = 1'b0;
                regs_next.disCount   = 2'h0;
            end else begin
                regs_next.disCount = regs_reg.disCount + 2'h1;
            end
        end else begin
            regs_next.disCount = 2'h0;
        end

        // Address set-up from the flash command decoder
        if (addrLoad) begin
            regs_next.wordAddr = addrIn;
        end

        if (!portUsable) begin
            // Unusable port drops chain and instruction state
            regs_next.resetChain = 1'b0;
            regs_next.irActive   = INSTR_BYPASS;
            regs_next.cmdPending = 1'b0;
        end else if (tckRise) begin
            case (tapState)
                TAP_RESET: begin
                    regs_next.irActive = INSTR_BYPASS;
                end
                TAP_CAP_IR: begin
                    regs_next.irShift = IR_CAPTURE;
                end
                TAP_SHIFT_IR: begin
                    regs_next.irShift = {regs_reg.tdiSync[1], regs_reg.irShift[IR_W-1:1]};
                end
                TAP_UPD_IR: begin
                    regs_next.irActive  = regs_reg.irShift;
                    regs_next.loadHigh  = 1'b0;
                    regs_next.firstLoad = 1'b1;
                    regs_next.readHigh  = 1'b0;
                end
                TAP_CAP_DR: begin
                    regs_next.bypassBit = 1'b0;
                    if (isInstr(regs_reg.irActive, COMMAND_ENTRY_INSTR)) begin
                        regs_next.cmdShift = cmdResult;
                        regs_next.cmdShift[BUSY_BIT] = flashBusy;
                    end
                    if (isInstr(regs_reg.irActive, PAGE_DUMP_INSTR) && regs_reg.progMode) begin
                        regs_next.cmdShift[BYTE_W-1:0] = regs_reg.readHigh ?
                            flashReadWord[15:8] : flashReadWord[7:0];
                        regs_next.readHigh = ~regs_reg.readHigh;
                        if (regs_reg.readHigh && !addrLoad) begin
                            regs_next.wordAddr = regs_reg.wordAddr + ADDR_W'(1);
                        end
                    end
                end
                TAP_SHIFT_DR: begin
                    case (regs_reg.irActive)
                        HOLD_IN_RESET_INSTR: begin
                            regs_next.resetChain = regs_reg.tdiSync[1];
                        end
                        UNLOCK_INSTR: begin
                            regs_next.keyShift = {regs_reg.tdiSync[1],
                                                  regs_reg.keyShift[KEY_W-1:1]};
                        end
                        COMMAND_ENTRY_INSTR: begin
                            regs_next.cmdShift = {regs_reg.tdiSync[1],
                                                  regs_reg.cmdShift[CMD_W-1:1]};
                        end
                        PAGE_FILL_INSTR, PAGE_DUMP_INSTR: begin
                            regs_next.cmdShift = {regs_reg.cmdShift[CMD_W-1:BYTE_W],
                                                  regs_reg.tdiSync[1],
                                                  regs_reg.cmdShift[BYTE_W-1:1]};
                        end
                        default: begin
                            regs_next.bypassBit = regs_reg.tdiSync[1];
                        end
                    endcase
                end
                TAP_UPD_DR: begin
                    if (isInstr(regs_reg.irActive, UNLOCK_INSTR)) begin
                        regs_next.progMode = (regs_reg.keyShift == UNLOCK_KEY);
                    end
                    if (isInstr(regs_reg.irActive, COMMAND_ENTRY_INSTR) && regs_reg.progMode) begin
                        regs_next.cmdApplied = regs_reg.cmdShift;
                        regs_next.cmdPending = 1'b1;
                    end
                    if (isInstr(regs_reg.irActive, PAGE_FILL_INSTR) && regs_reg.progMode) begin
                        if (!regs_reg.loadHigh && !regs_reg.firstLoad) begin
                            nextAddr = regs_reg.wordAddr + ADDR_W'(1);
                        end
                        if (!addrLoad) begin
                            regs_next.wordAddr = nextAddr;
                        end
                        regs_next.pageWrite.strobe = 1'b1;
                        regs_next.pageWrite.high   = regs_reg.loadHigh;
                        regs_next.pageWrite.addr   = nextAddr;
                        regs_next.pageWrite.data   = regs_reg.cmdShift[BYTE_W-1:0];
                        regs_next.loadHigh  = ~regs_reg.loadHigh;
                        regs_next.firstLoad = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        if (regs_reg.cmdPending && tapState == TAP_IDLE) begin
            regs_next.cmdStrobe  = 1'b1;
            regs_next.cmdPending = 1'b0;
        end

        // TDO changes on the falling edge, stable for the next rise
        if (!portUsable) begin
            regs_next.tdoOe = 1'b0;
            regs_next.tdo   = 1'b0;
        end else if (tckFall) begin
            regs_next.tdoOe = (tapState == TAP_SHIFT_IR) || (tapState == TAP_SHIFT_DR);
            if (tapState == TAP_SHIFT_IR) begin
                regs_next.tdo = regs_reg.irShift[0];
            end else begin
                case (regs_reg.irActive)
                    HOLD_IN_RESET_INSTR: regs_next.tdo = regs_reg.resetChain;
                    UNLOCK_INSTR:        regs_next.tdo = regs_reg.keyShift[0];
                    COMMAND_ENTRY_INSTR, PAGE_FILL_INSTR, PAGE_DUMP_INSTR: begin
                        regs_next.tdo = regs_reg.cmdShift[0];
                    end
                    default:             regs_next.tdo = regs_reg.bypassBit;
                endcase
            end
        end

        if (regs_next.resetChain || !regs_reg.rstnSync[1]) begin
            regs_next.coreReset = 1'b1;
            regs_next.timeout   = pickTimeout(clockOptionFuse);
        end else if (regs_reg.timeout != '0) begin
            regs_next.coreReset = 1'b1;
            regs_next.timeout   = regs_reg.timeout - TIMEOUT_W'(1);
        end else begin
            regs_next.coreReset = 1'b0;
        end
    end

    // State register; the key clears only here on power-on reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            regs_reg          <= '0;
            regs_reg.tckSync  <= 2'h0;
            regs_reg.rstnSync <= 2'h3;
            regs_reg.irActive <= INSTR_BYPASS;
            regs_reg.irShift  <= IR_CAPTURE;
            regs_reg.keyShift <= KEY_RESET;
            regs_reg.wordAddr <= ADDR_RESET;
            regs_reg.firstLoad <= 1'b1;
        end else begin
            regs_reg <= regs_next;
        end
    end

    // Outputs straight from flip-flops
    assign tdo                = regs_reg.tdo;
    assign tdoOe              = regs_reg.tdoOe;
    assign testPortDisableBit = regs_reg.disableBit;
    assign coreReset          = regs_reg.coreReset;
    assign flashCmd           = regs_reg.cmdApplied;
    assign flashCmdStrobe     = regs_reg.cmdStrobe;
    assign pageWrite          = regs_reg.pageWrite;
    assign wordAddr           = regs_reg.wordAddr;
    assign progMode           = regs_reg.progMode;

endmodule

// >>> logic/tap_controller.sv
// Purpose: Sixteen-state test access port sequencer stepped on TCK rising edges
// Assumes: tckRise is a one-cycle pulse and tmsLevel is already synchronised
// Notes:   holdReset parks the sequencer in test-logic reset
`timescale 1ns/1ps
module tap_controller (
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    reset,
    // Stepping
    input  wire logic                    holdReset,
    input  wire logic                    tckRise,
    input  wire logic                    tmsLevel,
    // Current state
    output jtag_prog_pkg::tap_state_t    tapState
);
    import jtag_prog_pkg::*;

    // All state of this module
    typedef struct packed {
        tap_state_t state;
    } tap_regs_t;

    tap_regs_t regs_reg;    // Registered state
    tap_regs_t regs_next;   // Next state

    // Standard transition graph of the access port
    function automatic tap_state_t step(input tap_state_t s, input logic m);
        case (s)
            TAP_RESET:    step = m ? TAP_RESET    : TAP_IDLE;
            TAP_IDLE:     step = m ? TAP_SEL_DR   : TAP_IDLE;
            TAP_SEL_DR:   step = m ? TAP_SEL_IR   : TAP_CAP_DR;
            TAP_CAP_DR:   step = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: step = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: step = m ? TAP_UPD_DR   : TAP_PAUSE_DR;
            TAP_PAUSE_DR: step = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: step = m ? TAP_UPD_DR   : TAP_SHIFT_DR;
            TAP_UPD_DR:   step = m ? TAP_SEL_DR   : TAP_IDLE;
            TAP_SEL_IR:   step = m ? TAP_RESET    : TAP_CAP_IR;
            TAP_CAP_IR:   step = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: step = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: step = m ? TAP_UPD_IR   : TAP_PAUSE_IR;
            TAP_PAUSE_IR: step = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: step = m ? TAP_UPD_IR   : TAP_SHIFT_IR;
            TAP_UPD_IR:   step = m ? TAP_SEL_DR   : TAP_IDLE;
            default:      step = TAP_RESET;
        endcase
    endfunction

    // Next state: hold in reset, else step on each TCK rise
    always_comb begin
        regs_next = regs_reg;
        if (holdReset) begin
            regs_next.state = TAP_RESET;
        end else if (tckRise) begin
            regs_next.state = step(regs_reg.state, tmsLevel);
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            regs_reg.state <= TAP_RESET;
        end else begin
            regs_reg <= regs_next;
        end
    end

    assign tapState = regs_reg.state;

endmodule
